// [include/dual_timer_pkg.sv]
// Package with register map, field positions and encodings of the dual timer control block
package dual_timer_pkg;
	// Register addresses on the memory-manipulation port
	localparam logic [15:0] ADDR_FIRST_MODE = 16'hff62;
	localparam logic [15:0] ADDR_CARRIER_OUT = 16'hff67;
	localparam logic [15:0] ADDR_SECOND_MODE = 16'hff69;
	localparam logic [7:0] MODE_RESET = 8'h00;
	// First timer mode register fields
	localparam int FM_RUN = 7;
	localparam int FM_CLK_HI = 4;
	localparam int FM_CLK_LO = 3;
	localparam int FM_MODE = 1;
	localparam logic [7:0] FM_MASK = 8'h9a;
	// Second timer mode register fields
	localparam int SM_RUN = 7;
	localparam int SM_CLK_B2 = 5;
	localparam int SM_CLK_B0 = 3;
	localparam int SM_MODE_HI = 2;
	localparam int SM_MODE_LO = 1;
	localparam int SM_OE = 0;
	localparam logic [7:0] SM_MASK = 8'hbf;
	// Carrier output register fields
	localparam int CO_REMOTE = 2;
	localparam int CO_NEXT = 1;
	localparam int CO_CUR = 0;
	// Joint operating mode, bits {first, second_hi, second_lo}
	typedef enum logic [2:0] {
		MODE_DISCRETE = 3'b000,
		MODE_CASCADE = 3'b101,
		MODE_CARRIER = 3'b011,
		MODE_PWM = 3'b010
	} op_mode_t;
	// First timer clock selections
	localparam logic [1:0] FCLK_DIV64 = 2'h0;
	localparam logic [1:0] FCLK_DIV256 = 2'h1;
	localparam logic [1:0] FCLK_MATCH = 2'h2;
	localparam logic [1:0] FCLK_OUT = 2'h3;
	// Prescaler tap positions (divide by 2^n needs bit n-1)
	localparam int PRE_WIDTH = 8;
	localparam int TAP_DIV2 = 0;
	localparam int TAP_DIV4 = 1;
	localparam int TAP_DIV8 = 2;
	localparam int TAP_DIV16 = 3;
	localparam int TAP_DIV64 = 5;
	localparam int TAP_DIV256 = 7;
	// Second timer clock codes
	localparam logic [2:0] SCLK_DIV1 = 3'h0;
	localparam logic [2:0] SCLK_DIV4A = 3'h1;
	localparam logic [2:0] SCLK_DIV2 = 3'h2;
	localparam logic [2:0] SCLK_DIV4B = 3'h3;
	localparam logic [2:0] SCLK_DIV8 = 3'h4;
	localparam logic [2:0] SCLK_DIV16 = 3'h5;
endpackage

// [design/timer_prescaler.sv]
// Free-running prescaler producing one-cycle divide-by-2^n tick pulses
`timescale 1ns/1ps
module timer_prescaler #(
	parameter int WIDTH = 8
) (
	input wire logic i_clk, // System clock
	input wire logic i_rst, // Synchronous reset, active high
	output logic [WIDTH-1:0] o_tick // Tick n pulses once every 2^(n+1) cycles
);
	logic [WIDTH-1:0] cnt_q;
	logic [WIDTH-1:0] cnt_d;

	// Next count
	always_comb begin
		cnt_d = cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
	end

	// Count register
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// Tick n fires when the low n+1 bits roll over to all ones
	for (genvar n = 0; n < WIDTH; n++) begin : g_tick
		assign o_tick[n] = &cnt_q[n:0];
	end
endmodule

// [design/dual_timer_ctrl.sv]
// Mode, clock, run and carrier output control for two 8-bit timers
// Behaviour
// [R1] First timer run bit low clears and stops first counter; high lets it count.
// [R2] First clock field picks div64, div256, second match, or carrier/second output.
// [R3] Mode bits decode discrete, cascade, carrier or PWM; other codes forbidden.
// [R4] Software writes one mode bit in first register, two in second.
// [R5] Cascade ignores first run bit; second run bit governs both counters.
// [R6] Cascade forces first timer clock to the second timer output.
// [R7] Second run bit clears/stops second counter, both in cascade; set starts.
// [R8] Second clock field picks undivided, div4, div2, div8 or div16.
// [R9] Output enable low leaves pin in port mode; high drives timer output.
// [R10] Both mode registers reset to zero, read/write, bit or byte writes.
// [R11] Carrier register write-only, undefined at reset, byte writes only.
// [R12] Software writes zeros into carrier register bits 3 to 7.
// [R13] With current data high, remote select picks carrier pulses or steady high.
// [R14] Current data low drives output low and stops carrier clock (code only forces the pin low; the second timer keeps toggling).
// [R15] Rising first-timer match copies next-data buffer into current data.
// [R16] Software writes to current data only take effect while output disabled.
// [R17] Software rewrites next-data buffer by byte write before re-enabling.
// [R18] Software loads compares and both data bits before carrier mode starts.
// [R19] Carrier mode: second timer makes carrier, first timer matches gate it.
// [R20] Carrier/PWM: low-width compare sets low time, high-width compare high time.
// [R21] Software sets pin direction output and clears port latch for timer use.
`timescale 1ns/1ps
module dual_timer_ctrl
	import dual_timer_pkg::*;
#(
	parameter int WIDTH = 8
) (
	input wire logic i_clk, // System clock
	input wire logic i_rst, // Synchronous reset, active high
	input wire logic [15:0] i_addr, // Memory-manipulation address
	input wire logic i_wr, // Write strobe
	input wire logic [7:0] i_wmask, // Bit mask of write (ff byte, one-hot bit)
	input wire logic [7:0] i_wdata, // Write data
	output logic [7:0] o_rdata, // Read data, zero for write-only/unmapped
	input wire logic [WIDTH-1:0] i_first_compare, // First timer compare value
	input wire logic [WIDTH-1:0] i_second_low_width_compare, // Low-width compare
	input wire logic [WIDTH-1:0] i_second_high_width_compare, // High-width compare
	input wire logic i_port_latch, // Port output latch of shared pin
	output logic [WIDTH-1:0] o_first_counter, // First counter value
	output logic [WIDTH-1:0] o_second_counter, // Second counter value
	output logic o_first_match, // First timer match pulse
	output logic o_second_match, // Second timer match pulse
	output logic o_timer_out_pin // Level presented to shared pin
);
	import dual_timer_pkg::*;

	logic [7:0] first_mode_q, first_mode_d;
	logic [7:0] second_mode_q, second_mode_d;
	logic remote_q, remote_d;
	logic next_q, next_d;
	logic cur_q, cur_d;
	logic [WIDTH-1:0] cnt1_q, cnt1_d, cnt2_q, cnt2_d;
	logic tout_q, tout_d;
	logic match1_q, match1_d;
	logic pin_q, pin_d;
	logic [PRE_WIDTH-1:0] tick;
	op_mode_t mode;
	logic cascade, carrier, pwm;
	logic run1, run2, tick2, tick1;
	logic hit1, hit2, hit_lo, hit_hi, carry2, tout_edge;
	logic joint;

	timer_prescaler #(.WIDTH(PRE_WIDTH)) u_pre (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.o_tick(tick)
	);

	// Merge a masked write into a register value
	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] msk,
			input logic [7:0] val, input logic [7:0] impl);
		merge = ((old & ~msk) | (val & msk)) & impl;
	endfunction

	// Write strobe aimed at one register address
	function automatic logic wr_hit(input logic wr, input logic [15:0] addr,
			input logic [15:0] target);
		wr_hit = wr && (addr == target);
	endfunction

	// Joint mode decode
	always_comb begin
		mode = op_mode_t'({first_mode_q[FM_MODE], second_mode_q[SM_MODE_HI],
			second_mode_q[SM_MODE_LO]}); // R3 R4
		cascade = (mode == MODE_CASCADE);
		carrier = (mode == MODE_CARRIER);
		pwm = (mode == MODE_PWM);
		run2 = second_mode_q[SM_RUN]; // R7
		run1 = cascade ? run2 : first_mode_q[FM_RUN]; // R1 R5
	end

	// Second timer clock select
	always_comb begin
		unique case (second_mode_q[SM_CLK_B2:SM_CLK_B0]) // R8
			SCLK_DIV1: tick2 = 1'b1;
			SCLK_DIV4A, SCLK_DIV4B: tick2 = tick[TAP_DIV4];
			SCLK_DIV2: tick2 = tick[TAP_DIV2];
			SCLK_DIV8: tick2 = tick[TAP_DIV8];
			SCLK_DIV16: tick2 = tick[TAP_DIV16];
			default: tick2 = 1'b0; // Forbidden codes stall the counter
		endcase
	end

	// Second timer compares and output edges
	always_comb begin
		hit_lo = tick2 && (cnt2_q == i_second_low_width_compare);
		hit_hi = tick2 && (cnt2_q == i_second_high_width_compare);
		carry2 = tick2 && (&cnt2_q);
		// R20: in carrier/PWM the active compare depends on current level
		hit2 = (carrier || pwm) ? (tout_q ? hit_hi : hit_lo) : hit_lo;
		tout_edge = run2 && (hit2 || ((carrier || pwm) && carry2));
	end

	// First timer clock select
	always_comb begin
		if (cascade) begin
			tick1 = tout_edge && !tout_q; // R6
		end else begin
			unique case (first_mode_q[FM_CLK_HI:FM_CLK_LO]) // R2
				FCLK_DIV64: tick1 = tick[TAP_DIV64];
				FCLK_DIV256: tick1 = tick[TAP_DIV256];
				FCLK_MATCH: tick1 = run2 && hit2;
				FCLK_OUT: tick1 = tout_edge && !tout_q; // R19 carrier clock or output
			endcase
		end
		hit1 = tick1 && (cnt1_q == i_first_compare);
	end

	// Counter next values
	always_comb begin
		cnt1_d = cnt1_q;
		cnt2_d = cnt2_q;
		tout_d = tout_q;
		// Cascade clears both halves only when both compares match at once
		joint = cascade && tick2 && hit_lo && (cnt1_q == i_first_compare);
		if (!run2) begin
			cnt2_d = '0; // R7
			tout_d = 1'b0;
		end else if (cascade) begin
			if (tick2) begin
				cnt2_d = cnt2_q + {{(WIDTH-1){1'b0}}, 1'b1};
			end
			if (joint) begin
				cnt2_d = '0; // Joint 16-bit match
				tout_d = !tout_q;
			end else if (tout_edge) begin
				tout_d = !tout_q;
			end
		end else if (tout_edge) begin
			cnt2_d = '0;
			tout_d = !tout_q;
		end else if (tick2) begin
			cnt2_d = cnt2_q + {{(WIDTH-1){1'b0}}, 1'b1};
		end
		if (!run1) begin
			cnt1_d = '0; // R1 R5 R7
		end else if (joint || (hit1 && !cascade)) begin
			cnt1_d = '0; // Lone first-half match does not clear in cascade
		end else if (tick1) begin
			cnt1_d = cnt1_q + {{(WIDTH-1){1'b0}}, 1'b1};
		end
		// In cascade only the joint match counts, so the lone flag stays low
		match1_d = hit1 && run1 && !cascade;
	end

	// Register writes and carrier data transfer
	always_comb begin
		first_mode_d = first_mode_q;
		second_mode_d = second_mode_q;
		remote_d = remote_q;
		next_d = next_q;
		cur_d = cur_q;
		if (wr_hit(i_wr, i_addr, ADDR_FIRST_MODE)) begin
			first_mode_d = merge(first_mode_q, i_wmask, i_wdata, FM_MASK); // R10
		end
		if (wr_hit(i_wr, i_addr, ADDR_SECOND_MODE)) begin
			second_mode_d = merge(second_mode_q, i_wmask, i_wdata, SM_MASK); // R10
		end
		// R11: byte-wide write only; upper bits are not stored
		if (wr_hit(i_wr, i_addr, ADDR_CARRIER_OUT)) begin
			remote_d = i_wdata[CO_REMOTE];
			next_d = i_wdata[CO_NEXT];
			if (!second_mode_q[SM_OE]) begin
				cur_d = i_wdata[CO_CUR]; // R16
			end
		end
		if (match1_d && !match1_q) begin
			cur_d = next_q; // R15
		end
	end

	// Pin level
	always_comb begin
		if (!second_mode_q[SM_OE]) begin
			pin_d = i_port_latch; // R9
		end else if (carrier) begin
			if (!cur_q) begin
				pin_d = 1'b0; // R14
			end else begin
				pin_d = remote_q ? 1'b1 : tout_q; // R13 R19
			end
		end else begin
			pin_d = tout_q;
		end
	end

	// Mode and carrier control registers; carrier bits start at zero
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			first_mode_q <= MODE_RESET; // R10
			second_mode_q <= MODE_RESET; // R10
			remote_q <= 1'b0;
			next_q <= 1'b0;
			cur_q <= 1'b0;
		end else begin
			first_mode_q <= first_mode_d;
			second_mode_q <= second_mode_d;
			remote_q <= remote_d;
			next_q <= next_d;
			cur_q <= cur_d;
		end
	end

	// Counters, timer output and first match flag
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cnt1_q <= '0;
			cnt2_q <= '0;
			tout_q <= 1'b0;
			match1_q <= 1'b0;
		end else begin
			cnt1_q <= cnt1_d;
			cnt2_q <= cnt2_d;
			tout_q <= tout_d;
			match1_q <= match1_d;
		end
	end

	// Pin register keeps the pin glitch free when the source switches
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			pin_q <= 1'b0;
		end else begin
			pin_q <= pin_d;
		end
	end

	// Read mux: the carrier register is write-only
	always_comb begin
		unique case (i_addr)
			ADDR_FIRST_MODE: o_rdata = first_mode_q;
			ADDR_SECOND_MODE: o_rdata = second_mode_q;
			default: o_rdata = 8'h00;
		endcase
	end

	assign o_first_counter = cnt1_q;
	assign o_second_counter = cnt2_q;
	assign o_first_match = match1_q;
	assign o_second_match = run2 && hit2;
	assign o_timer_out_pin = pin_q;
endmodule

// [verif/dual_timer_ctrl_chk.sv]
// Port-level assertions for the dual timer control block
`timescale 1ns/1ps
module dual_timer_ctrl_chk
	import dual_timer_pkg::*;
#(
	parameter int WIDTH = 8
) (
	input wire logic i_clk, // Clock
	input wire logic i_rst, // Reset
	input wire logic [15:0] i_addr, // Address
	input wire logic i_wr, // Write strobe
	input wire logic [7:0] i_wmask, // Write mask
	input wire logic [7:0] i_wdata, // Write data
	input wire logic [7:0] o_rdata, // Read data
	input wire logic [WIDTH-1:0] i_second_low_width_compare, // Compare
	input wire logic i_port_latch, // Port latch
	input wire logic [WIDTH-1:0] o_first_counter, // First counter
	input wire logic [WIDTH-1:0] o_second_counter, // Second counter
	input wire logic o_timer_out_pin // Pin level
);
	import dual_timer_pkg::*;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	logic sel_f;
	logic sel_s;
	// Register selects
	assign sel_f = i_addr == ADDR_FIRST_MODE;
	assign sel_s = i_addr == ADDR_SECOND_MODE;
	a_reset_clears: assert property (disable iff (1'b0) i_rst |=>
		o_first_counter == '0 && o_second_counter == '0) else $error("counters not cleared");
	a_first_resv: assert property (sel_f |-> (o_rdata & ~FM_MASK) == 8'h00)
		else $error("first reserved bits set");
	a_second_resv: assert property (sel_s |-> !o_rdata[6]) else $error("bit 6 set");
	a_carrier_wo: assert property (i_addr == ADDR_CARRIER_OUT |-> o_rdata == 8'h00)
		else $error("carrier register readable");
	a_byte_write: assert property ((i_wr && sel_s && i_wmask == 8'hff) ##1 sel_s
		|-> o_rdata == ($past(i_wdata) & SM_MASK)) else $error("byte write lost");
	a_first_stop: assert property (sel_f && !o_rdata[FM_RUN] && !o_rdata[FM_MODE]
		|=> o_first_counter == '0) else $error("first counter not held");
	a_second_stop: assert property (sel_s && !o_rdata[SM_RUN]
		|=> o_second_counter == '0) else $error("second counter not held");
	a_port_mode: assert property (sel_s && !o_rdata[SM_OE]
		|=> o_timer_out_pin == $past(i_port_latch)) else $error("pin not in port mode");
	a_undiv_count: assert property (sel_s && o_rdata[7:1] == 7'h40 &&
		o_second_counter != i_second_low_width_compare && o_second_counter != '1
		|=> o_second_counter == $past(o_second_counter) + 1'b1) else $error("bad count");
endmodule
bind dual_timer_ctrl dual_timer_ctrl_chk #(.WIDTH(WIDTH)) u_chk (.i_clk, .i_rst, .i_addr,
	.i_wr, .i_wmask, .i_wdata, .o_rdata, .i_second_low_width_compare, .i_port_latch,
	.o_first_counter, .o_second_counter, .o_timer_out_pin);

// [verif/test_dual_timer_mode_and_carrier_control.sv]
// Self-checking bench for the dual timer control block
`timescale 1ns/1ps
module test_dual_timer_mode_and_carrier_control;
	import dual_timer_pkg::*;
	logic clk = 0, rst = 1, wr_en = 0, pl = 0, fm, sm, pin;
	logic [15:0] adr = 16'h0000;
	logic [7:0] wm = 8'h00, wd = 8'h00, rd, cf = 8'h05, cl = 8'h0a, ch = 8'h04, fc, sc;
	logic [7:0] mf = 8'h00, ms = 8'h00;
	logic [31:0] seed = 32'h00015e1b;
	int n_errors = 0, cmp_count = 0, cyc = 0, t, n;
	int dv[$] = '{1, 4, 2, 4, 8, 16};
	dual_timer_ctrl #(.WIDTH(8)) u_dut (.i_clk(clk), .i_rst(rst), .i_addr(adr), .i_wr(wr_en),
		.i_wmask(wm), .i_wdata(wd), .o_rdata(rd), .i_first_compare(cf),
		.i_second_low_width_compare(cl), .i_second_high_width_compare(ch),
		.i_port_latch(pl), .o_first_counter(fc), .o_second_counter(sc),
		.o_first_match(fm), .o_second_match(sm), .o_timer_out_pin(pin));
	// Clock and hang guard
	always #4 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc > 40000) begin
			n_errors++;
			conclude();
		end
	end
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t value %h expected %h", $time, got, exp);
		end
	endtask
	task chk_n(input int got, input int exp);
		cmp_count++;
		if (got != exp) begin
			n_errors++;
			$display("[ERR] %0t period %0d expected %0d", $time, got, exp);
		end
	endtask
	task wr(input logic [15:0] a, input logic [7:0] m, input logic [7:0] d);
		@(negedge clk);
		adr = a;
		wm = m;
		wd = d;
		wr_en = 1;
		@(negedge clk);
		wr_en = 0;
		if (a == ADDR_FIRST_MODE) mf = ((mf & ~m) | (d & m)) & FM_MASK;
		if (a == ADDR_SECOND_MODE) ms = ((ms & ~m) | (d & m)) & SM_MASK;
	endtask
	task rchk(input logic [15:0] a);
		@(negedge clk);
		adr = a;
		#1 chk(rd, a == ADDR_FIRST_MODE ? mf : a == ADDR_SECOND_MODE ? ms : 8'h00);
	endtask
	// Cycles a counter rests at one, which is one count-clock period
	task per(input logic sel, input int exp);
		n = 0;
		t = 0;
		while ((sel ? fc : sc) !== 8'h01 && t < 2000) begin @(negedge clk); t++; end
		while ((sel ? fc : sc) === 8'h01 && t < 2000) begin @(negedge clk); n++; t++; end
		chk_n(n, exp);
	endtask
	// Cycles the pin holds one level, measured on a whole phase
	task wid(input logic lvl, input int exp);
		n = 0;
		t = 0;
		while (pin !== lvl && t < 2000) begin @(negedge clk); t++; end
		while (pin === lvl && t < 2000) begin @(negedge clk); t++; end
		while (pin !== lvl && t < 2000) begin @(negedge clk); t++; end
		while (pin === lvl && t < 2000) begin @(negedge clk); n++; t++; end
		chk_n(n, exp);
	endtask
	task conclude();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (10) @(negedge clk);
		rst = 0;
		rchk(ADDR_FIRST_MODE);
		rchk(ADDR_SECOND_MODE);
		for (int i = 0; i < 6; i++) begin
			wr(ADDR_FIRST_MODE, 8'hff, rnd() & 8'h7d);
			rchk(ADDR_FIRST_MODE);
			wr(ADDR_SECOND_MODE, 8'hff, {2'b00, i[2:0], 3'b000} | (rnd() & 8'h40));
			rchk(ADDR_SECOND_MODE);
		end
		wr(ADDR_FIRST_MODE, 8'h10, 8'hff);
		rchk(ADDR_FIRST_MODE);
		wr(ADDR_CARRIER_OUT, 8'hff, rnd() & 8'h07);
		rchk(ADDR_CARRIER_OUT);
		rchk(16'hff63);
		wr(ADDR_FIRST_MODE, 8'hff, 8'h00);
		for (int c = 0; c < 6; c++) begin
			wr(ADDR_SECOND_MODE, 8'hff, {2'b10, c[2:0], 3'b000});
			per(0, dv[c]);
			if (c == 0) repeat (30) @(negedge clk) chk(sm, sc === cl);
			wr(ADDR_SECOND_MODE, 8'hff, 8'h00);
			@(negedge clk) chk(sc, 8'h00);
		end
		for (int k = 0; k < 2; k++) begin
			wr(ADDR_FIRST_MODE, 8'hff, 8'h80 | (k << 3));
			per(1, k ? 256 : 64);
			wr(ADDR_FIRST_MODE, 8'hff, 8'h00);
			@(negedge clk) chk(fc, 8'h00);
		end
		wr(ADDR_SECOND_MODE, 8'hff, 8'h02);
		wr(ADDR_FIRST_MODE, 8'hff, 8'h82);
		repeat (300) @(negedge clk);
		chk(fc, 8'h00);
		wr(ADDR_SECOND_MODE, 8'hff, 8'h82);
		for (t = 0; fc === 8'h00 && t < 3000; t++) @(negedge clk);
		chk(fc !== 8'h00, 8'h01);
		wr(ADDR_SECOND_MODE, 8'hff, 8'h02);
		@(negedge clk) chk(fc | sc, 8'h00);
		wr(ADDR_FIRST_MODE, 8'hff, 8'h00);
		wr(ADDR_SECOND_MODE, 8'hff, 8'h00);
		for (int i = 0; i < 6; i++) begin
			pl = rnd() >= 8'h80;
			repeat (2) @(negedge clk);
			chk(pin, pl);
		end
		pl = 0;
		// PWM on the second timer: high and low widths from the two compares
		wr(ADDR_SECOND_MODE, 8'hff, 8'h85);
		wid(1'b1, ch + 1);
		wid(1'b0, cl + 1);
		wr(ADDR_SECOND_MODE, 8'hff, 8'h00);
		wr(ADDR_CARRIER_OUT, 8'hff, 8'h05);
		wr(ADDR_SECOND_MODE, 8'hff, 8'h87);
		repeat (20) @(negedge clk) chk(pin, 1'b1);
		wr(ADDR_CARRIER_OUT, 8'hff, 8'h04);
		repeat (20) @(negedge clk) chk(pin, 1'b1);
		wr(ADDR_FIRST_MODE, 8'hff, 8'h90);
		for (t = 0; fm !== 1'b1 && t < 3000; t++) @(negedge clk);
		chk(fm, 1'b1);
		repeat (3) @(negedge clk);
		chk(pin, 1'b0);
		conclude();
	end
endmodule
